// ### rtl/pcar_if.sv
// register access carrier between the spi front end and the register bank
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface pcar_if;
	logic [6:0] rd_addr; // address byte being completed
	logic [31:0] rd_data; // answer of the bank, combinational
	logic wr_stb; // one-cycle write pulse
	logic [6:0] wr_addr; // address of the write
	logic [31:0] wr_data; // data of the write

	modport link (output rd_addr, output wr_stb, output wr_addr,
		output wr_data, input rd_data);
	modport bank (input rd_addr, input wr_stb, input wr_addr,
		input wr_data, output rd_data);
endinterface

// ### rtl/pcar_pkg.sv
// types shared by the spi front end and the register bank
// assumes pcar_regs.svh is on the include path
package pcar_pkg;
	`include "pcar_regs.svh"

	// input stage encodings of channel 0
	typedef enum logic [3:0] {
		PCAR_STAGE_POS_VS_NEG = 4'h0,
		PCAR_STAGE_GND_VS_NEG = 4'h1,
		PCAR_STAGE_QUARTER_SUPPLY = 4'h2,
		PCAR_STAGE_THREE_QUARTER = 4'h3,
		PCAR_STAGE_POS_VS_GND = 4'h4
	} pcar_stage_mode_t;

	// state of the spi front end
	typedef struct packed {
		logic sck_prev;
		logic [`PCAR_CNT_W-1:0] bit_cnt;
		logic [39:0] rx;
		logic [31:0] tx;
		logic miso;
		logic miso_oe;
		logic wr_stb;
		logic [6:0] wr_addr;
		logic [31:0] wr_data;
	} pcar_spi_state_t;

	// state of the register bank and the phase datapath
	typedef struct packed {
		logic [1:0] ux_sel;
		logic [1:0] v_sel;
		logic [1:0] wy_sel;
		logic [31:0] ext_current;
		logic [3:0] stage_cfg;
		logic [15:0] ux_current;
		logic [15:0] v_current;
		logic [15:0] wy_current;
	} pcar_reg_state_t;
endpackage

// ### rtl/pcar_regs.svh
// register addresses, field positions, reset values of the current router
// assumes inclusion by bare name from the package; the design modules take the macros from it
`ifndef PCAR_REGS_SVH
`define PCAR_REGS_SVH

// spi frame layout: write flag, 7-bit address, 32-bit data, msb first
`define PCAR_FRAME_BITS 6'h28
`define PCAR_ADDR_BITS 6'h08
`define PCAR_CNT_W 6

// register addresses as seen in the spi address byte
`define PCAR_ADDR_PHASE_SEL 7'h0A
`define PCAR_ADDR_EXT_CURRENT 7'h0B
`define PCAR_ADDR_STAGE_CFG 7'h0C

// phase source select field positions
`define PCAR_UX_LSB 24
`define PCAR_UX_MSB 25
`define PCAR_V_LSB 26
`define PCAR_V_MSB 27
`define PCAR_WY_LSB 28
`define PCAR_WY_MSB 29

// phase source codes
`define PCAR_SRC_CH0 2'h0
`define PCAR_SRC_CH1 2'h1
`define PCAR_SRC_CH2 2'h2
`define PCAR_SRC_RSVD 2'h3

// reset values of the select fields
`define PCAR_UX_RESET 2'h0
`define PCAR_V_RESET 2'h1
`define PCAR_WY_RESET 2'h2

// external current register halves
`define PCAR_EXT0_LSB 0
`define PCAR_EXT0_MSB 15
`define PCAR_EXT1_LSB 16
`define PCAR_EXT1_MSB 31
`define PCAR_EXT_RESET 32'h0000_0000

// input stage field of channel 0
`define PCAR_STAGE_LSB 0
`define PCAR_STAGE_MSB 3
`define PCAR_STAGE_RESET 4'h0

`endif

// ### rtl/pcar_spi_slave.sv
// spi slave front end: 40-bit frames, mode 3, msb first
// assumes sck, csn and mosi are synchronous to clk_sys and much slower
`timescale 1ns/1ps
module pcar_spi_slave
	import pcar_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// spi pins
	input wire logic spi_sck,
	input wire logic spi_csn_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// register side
	pcar_if.link regs
);
	pcar_spi_state_t st; // registered state
	pcar_spi_state_t next_st; // next state
	logic sck_rise; // master samples here, so do we
	logic sck_fall; // master shifts here, so do we

	assign sck_rise = spi_sck && !st.sck_prev;
	assign sck_fall = !spi_sck && st.sck_prev;
	// address byte as it will stand after this rising edge
	assign regs.rd_addr = {st.rx[5:0], spi_mosi};

	// frame decode and shifting
	always_comb begin
		next_st = st;
		next_st.sck_prev = spi_sck;
		next_st.wr_stb = 1'b0;
		next_st.miso_oe = !spi_csn_n;
		if (spi_csn_n) begin
			// deselect aborts any partial frame, no write happens
			next_st.bit_cnt = '0;
			next_st.miso = 1'b0;
		end else if (sck_rise) begin
			if (st.bit_cnt != `PCAR_FRAME_BITS) begin
				next_st.rx = {st.rx[38:0], spi_mosi};
				next_st.bit_cnt = st.bit_cnt + 1'b1;
			end
			// after the address byte, capture the answer for shifting out
			if (st.bit_cnt == `PCAR_ADDR_BITS - 1'b1) begin
				next_st.tx = regs.rd_data;
			end
			// last bit with the write flag set commits the write
			if (st.bit_cnt == `PCAR_FRAME_BITS - 1'b1 && st.rx[38]) begin
				next_st.wr_stb = 1'b1;
				next_st.wr_addr = st.rx[37:31];
				next_st.wr_data = {st.rx[30:0], spi_mosi};
			end
		end else if (sck_fall) begin
			// the first byte answers zeros, then the read word follows
			if (st.bit_cnt >= `PCAR_ADDR_BITS &&
				st.bit_cnt != `PCAR_FRAME_BITS) begin
				next_st.miso = st.tx[31];
				next_st.tx = {st.tx[30:0], 1'b0};
			end else begin
				next_st.miso = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
			st.sck_prev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign spi_miso = st.miso;
	assign spi_miso_oe = st.miso_oe;
	assign regs.wr_stb = st.wr_stb;
	assign regs.wr_addr = st.wr_addr;
	assign regs.wr_data = st.wr_data;
endmodule

// ### rtl/pcar_top.sv
// phase current routing register bank with its spi register access
// assumes spi pins synchronous to clk_sys, converter samples on clk_sys
`timescale 1ns/1ps
module pcar_top
	import pcar_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// spi slave pins
	input wire logic spi_sck,
	input wire logic spi_csn_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// raw converter samples
	input wire logic [15:0] conv_ch0_sample,
	input wire logic [15:0] conv_ch1_sample,
	input wire logic [15:0] conv_ch2_sample,
	// raw source steering from the raw channel select logic
	input wire logic ch0_use_host,
	input wire logic ch1_use_host,
	// routed phase currents
	output logic [15:0] ux_current,
	output logic [15:0] v_current,
	output logic [15:0] wy_current,
	// configuration towards the converters and the datapath
	output logic [3:0] input_stage_ch0_mode,
	output logic [15:0] host_current_ch0_value,
	output logic [15:0] host_current_ch1_value,
	output logic [1:0] ux_phase_current_source_sel,
	output logic [1:0] v_phase_current_source_sel,
	output logic [1:0] wy_phase_current_source_sel
);
	pcar_if acc (); // register access between spi and the bank
	pcar_reg_state_t st; // registered state
	pcar_reg_state_t next_st; // next state
	logic [15:0] current_channel_0; // channel 0 after host override
	logic [15:0] current_channel_1; // channel 1 after host override
	logic [15:0] current_channel_2; // channel 2, converter only
	logic [31:0] phase_sel_word; // read image of the select register

	// spi front end
	pcar_spi_slave u_spi (
		.clk_sys(clk_sys),
		.rst(rst),
		.spi_sck(spi_sck),
		.spi_csn_n(spi_csn_n),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe),
		.regs(acc.link)
	);

	// channel sources: converter, or host-written value for channels 0 and 1
	// the host path exists for external converters and cascade tests;
	// closing the loops on it in normal running costs control quality
	always_comb begin
		current_channel_0 = conv_ch0_sample;
		current_channel_1 = conv_ch1_sample;
		current_channel_2 = conv_ch2_sample;
		if (ch0_use_host) begin
			current_channel_0 = st.ext_current[`PCAR_EXT0_MSB:`PCAR_EXT0_LSB];
		end
		if (ch1_use_host) begin
			current_channel_1 = st.ext_current[`PCAR_EXT1_MSB:`PCAR_EXT1_LSB];
		end
	end

	// phase mux, a reserved code yields zero rather than a stale value
	function automatic logic [15:0] pcar_pick(input logic [1:0] sel,
		input logic [15:0] c0, input logic [15:0] c1,
		input logic [15:0] c2);
		logic [15:0] res;
		res = 16'h0000;
		case (sel)
			`PCAR_SRC_CH0: res = c0;
			`PCAR_SRC_CH1: res = c1;
			`PCAR_SRC_CH2: res = c2;
			default: res = 16'h0000;
		endcase
		return res;
	endfunction

	// read image of the select register, other bits read zero
	always_comb begin
		phase_sel_word = 32'h0000_0000;
		phase_sel_word[`PCAR_UX_MSB:`PCAR_UX_LSB] = st.ux_sel;
		phase_sel_word[`PCAR_V_MSB:`PCAR_V_LSB] = st.v_sel;
		phase_sel_word[`PCAR_WY_MSB:`PCAR_WY_LSB] = st.wy_sel;
	end

	// read decode, unmapped addresses answer zero
	always_comb begin
		case (acc.rd_addr)
			`PCAR_ADDR_PHASE_SEL: acc.rd_data = phase_sel_word;
			`PCAR_ADDR_EXT_CURRENT: acc.rd_data = st.ext_current;
			`PCAR_ADDR_STAGE_CFG: acc.rd_data = {28'h0000000, st.stage_cfg};
			default: acc.rd_data = 32'h0000_0000;
		endcase
	end

	// register writes and the registered phase datapath
	always_comb begin
		next_st = st;
		if (acc.wr_stb) begin
			case (acc.wr_addr)
				`PCAR_ADDR_PHASE_SEL: begin
					// the whole field is stored; code 3 is the host's to avoid
					next_st.ux_sel =
						acc.wr_data[`PCAR_UX_MSB:`PCAR_UX_LSB];
					next_st.v_sel =
						acc.wr_data[`PCAR_V_MSB:`PCAR_V_LSB];
					next_st.wy_sel =
						acc.wr_data[`PCAR_WY_MSB:`PCAR_WY_LSB];
				end
				`PCAR_ADDR_EXT_CURRENT: begin
					next_st.ext_current = acc.wr_data;
				end
				`PCAR_ADDR_STAGE_CFG: begin
					next_st.stage_cfg =
						acc.wr_data[`PCAR_STAGE_MSB:`PCAR_STAGE_LSB];
				end
				default: begin
					// writes to other addresses are dropped
				end
			endcase
		end
		// phase currents follow the present selects one cycle later
		next_st.ux_current = pcar_pick(st.ux_sel, current_channel_0,
			current_channel_1, current_channel_2);
		next_st.v_current = pcar_pick(st.v_sel, current_channel_0,
			current_channel_1, current_channel_2);
		next_st.wy_current = pcar_pick(st.wy_sel, current_channel_0,
			current_channel_1, current_channel_2);
	end

	// state register with documented select defaults
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st.ux_sel <= `PCAR_UX_RESET;
			st.v_sel <= `PCAR_V_RESET;
			st.wy_sel <= `PCAR_WY_RESET;
			st.ext_current <= `PCAR_EXT_RESET;
			st.stage_cfg <= `PCAR_STAGE_RESET;
			st.ux_current <= 16'h0000;
			st.v_current <= 16'h0000;
			st.wy_current <= 16'h0000;
		end else begin
			st <= next_st;
		end
	end

	// outputs, all from flops
	assign ux_current = st.ux_current;
	assign v_current = st.v_current;
	assign wy_current = st.wy_current;
	// codes 5 to 15 pass unchanged; the front end decides what they mean
	assign input_stage_ch0_mode = st.stage_cfg;
	assign host_current_ch0_value = st.ext_current[`PCAR_EXT0_MSB:`PCAR_EXT0_LSB];
	assign host_current_ch1_value = st.ext_current[`PCAR_EXT1_MSB:`PCAR_EXT1_LSB];
	assign ux_phase_current_source_sel = st.ux_sel;
	assign v_phase_current_source_sel = st.v_sel;
	assign wy_phase_current_source_sel = st.wy_sel;
endmodule

// ### tb/pcar_host_model.sv
// host side spi master model for the phase current router
// assumes mode 3, 40-bit frames, sck at a quarter of clk_sys
`timescale 1ns/1ps
module pcar_host_model (
	// clock
	input wire logic clk_sys,
	// spi pins
	input wire logic spi_miso,
	output logic spi_sck,
	output logic spi_csn_n,
	output logic spi_mosi
);
	initial begin
		spi_sck = 1'b1; // sck idles high between frames
		spi_csn_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// one frame; sck low and high two clocks each, a period of four clocks
	// external values only feed routing checks, never a loop
	// the bench never sends select code 3
	task automatic xfer(input logic [39:0] f, output logic [31:0] r);
		@(negedge clk_sys);
		spi_csn_n = 1'b0;
		for (int i = 39; i >= 0; i--) begin
			@(negedge clk_sys);
			spi_sck = 1'b0;
			spi_mosi = f[i];
			repeat (2) @(negedge clk_sys);
			r = {r[30:0], spi_miso}; // taken just before sck rises
			spi_sck = 1'b1;
			@(negedge clk_sys);
		end
		@(negedge clk_sys);
		spi_csn_n = 1'b1;
		spi_mosi = ~spi_mosi; // released line shows no stale bit
		repeat (2) @(negedge clk_sys);
	endtask
endmodule

// ### tb/pcar_properties.sv
// assertions on the ports of the phase current router
// assumes it is bound onto pcar_top, one clock domain
`timescale 1ns/1ps
module pcar_top_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// spi pins
	input wire logic spi_sck,
	input wire logic spi_csn_n,
	input wire logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe,
	// converter side
	input wire logic [15:0] conv_ch0_sample,
	input wire logic [15:0] conv_ch1_sample,
	input wire logic [15:0] conv_ch2_sample,
	input wire logic ch0_use_host,
	input wire logic ch1_use_host,
	// routed currents and configuration
	input wire logic [15:0] ux_current,
	input wire logic [15:0] v_current,
	input wire logic [15:0] wy_current,
	input wire logic [3:0] input_stage_ch0_mode,
	input wire logic [15:0] host_current_ch0_value,
	input wire logic [15:0] host_current_ch1_value,
	input wire logic [1:0] ux_phase_current_source_sel,
	input wire logic [1:0] v_phase_current_source_sel,
	input wire logic [1:0] wy_phase_current_source_sel
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// raw channels after the host override
	logic [15:0] s0, s1;
	assign s0 = ch0_use_host ? host_current_ch0_value : conv_ch0_sample;
	assign s1 = ch1_use_host ? host_current_ch1_value : conv_ch1_sample;
	// code 3 has no source, so it must give zero
	// every value comes in as an argument so that $past samples it
	function automatic logic [15:0] pick(input logic [1:0] s,
		input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] c2);
		return s == 2'h0 ? c0 : s == 2'h1 ? c1 : s == 2'h2 ? c2 : 16'h0;
	endfunction
	ux_route_a:
	assert property (!$past(rst) |->
		ux_current == $past(pick(ux_phase_current_source_sel, s0, s1,
		conv_ch2_sample)))
		else $error("ux current wrong");
	v_route_a:
	assert property (!$past(rst) |->
		v_current == $past(pick(v_phase_current_source_sel, s0, s1,
		conv_ch2_sample)))
		else $error("v current wrong");
	wy_route_a:
	assert property (!$past(rst) |->
		wy_current == $past(pick(wy_phase_current_source_sel, s0, s1,
		conv_ch2_sample)))
		else $error("wy current wrong");
	reset_vals_a:
	assert property ($fell(rst) |-> ux_phase_current_source_sel == 2'h0 &&
		v_phase_current_source_sel == 2'h1 &&
		wy_phase_current_source_sel == 2'h2 && input_stage_ch0_mode == 4'h0 &&
		host_current_ch0_value == 16'h0000 &&
		host_current_ch1_value == 16'h0000)
		else $error("reset values wrong");
	sel_stable_a:
	assert property (spi_csn_n [*5] |=> $stable({ux_phase_current_source_sel,
		v_phase_current_source_sel, wy_phase_current_source_sel}))
		else $error("select changed without a frame");
	ext_stable_a:
	assert property (spi_csn_n [*5] |=> $stable({host_current_ch1_value,
		host_current_ch0_value, input_stage_ch0_mode}))
		else $error("register changed without a frame");
	oe_follow_a:
	assert property (!$past(rst) |-> spi_miso_oe == !$past(spi_csn_n))
		else $error("miso enable wrong");
	miso_hold_a:
	assert property (!spi_csn_n && spi_sck && $past(spi_sck) &&
		$past(spi_sck, 2) |-> $stable(spi_miso))
		else $error("miso moved while sck high");
endmodule

bind pcar_top pcar_top_checker chk_u (.*);

// ### tb/test_phase_current_adc_routing.sv
// self-checking bench for the phase current router
// assumes the host model drives the spi pins like the real host
`timescale 1ns/1ps
module test_phase_current_adc_routing;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic spi_sck, spi_csn_n, spi_mosi, spi_miso, spi_miso_oe;
	logic [15:0] conv_ch0_sample = 16'h1111; // distinct per channel
	logic [15:0] conv_ch1_sample = 16'h2222;
	logic [15:0] conv_ch2_sample = 16'h3333;
	logic ch0_use_host = 1'b0;
	logic ch1_use_host = 1'b0;
	logic [15:0] ux_current, v_current, wy_current;
	logic [15:0] host_current_ch0_value, host_current_ch1_value;
	logic [3:0] input_stage_ch0_mode;
	logic [1:0] ux_phase_current_source_sel, v_phase_current_source_sel;
	logic [1:0] wy_phase_current_source_sel;
	logic [31:0] r;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	pcar_top dut_u (.*);
	pcar_host_model host_u (.*);
	initial forever #5 clk_sys = ~clk_sys;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// write, then let the register and the currents settle
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		host_u.xfer({1'b1, a, d}, r);
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic rd(input logic [6:0] a, input logic [31:0] e);
		host_u.xfer({1'b0, a, 32'h0}, r);
		chk("read", e, r);
	endtask
	// expected current of a code, from the bench's own values
	function automatic logic [15:0] pick(input int s);
		if (s == 0)
			return ch0_use_host ? 16'h1234 : conv_ch0_sample;
		if (s == 1)
			return ch1_use_host ? 16'hBEEF : conv_ch1_sample;
		return conv_ch2_sample;
	endfunction
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, far above the 19 frames of the run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test;
		end
	end
	initial begin
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		rd(7'h0A, 32'h2400_0000);
		$display("test reset done");
		wr(7'h0B, 32'hBEEF_1234);
		chk("ext lo", 32'h1234, {16'h0, host_current_ch0_value});
		chk("ext hi", 32'hBEEF, {16'h0, host_current_ch1_value});
		$display("test ext done");
		// second pass routes channels 0 and 1 from the host values
		for (int p = 0; p < 2; p++) begin
			ch0_use_host = p[0];
			ch1_use_host = p[0];
			for (int k = 0; k < 3; k++) begin
				wr(7'h0A, {2'h0, 2'((k + 2) % 3), 2'((k + 1) % 3), 2'(k),
					24'h0});
				chk("ux sel", 32'(k),
					{30'h0, ux_phase_current_source_sel});
				chk("v sel", 32'((k + 1) % 3),
					{30'h0, v_phase_current_source_sel});
				chk("wy sel", 32'((k + 2) % 3),
					{30'h0, wy_phase_current_source_sel});
				chk("ux", {16'h0, pick(k)}, {16'h0, ux_current});
				chk("v", {16'h0, pick((k + 1) % 3)}, {16'h0, v_current});
				chk("wy", {16'h0, pick((k + 2) % 3)}, {16'h0, wy_current});
			end
		end
		$display("test routing done");
		for (int m = 0; m < 5; m++) begin
			wr(7'h0C, 32'(m));
			chk("stage", 32'(m), {28'h0, input_stage_ch0_mode});
		end
		rd(7'h0C, 32'h4);
		$display("test stage done");
		// unmapped write that would alias 0x0B on a short decode
		wr(7'h7B, 32'h0);
		rd(7'h0B, 32'hBEEF_1234);
		rd(7'h7B, 32'h0);
		$display("test unmapped done");
		// mid-run reset brings back the defaults and clears the host values
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		rd(7'h0A, 32'h2400_0000);
		rd(7'h0B, 32'h0);
		chk("stage reset", 32'h0, {28'h0, input_stage_ch0_mode});
		$display("test second reset done");
		stop_test;
	end
endmodule
